/* rtl/pcs_pkg.sv */
// Constants for the type-0 configuration space header of a memory-mapped serial target.
// Assumes byte offsets on a 32-bit configuration data path.
package pcs_pkg;
  // Word offsets, byte addresses
  localparam logic [7:0] OFF_IDENTITY = 8'h00;
  localparam logic [7:0] OFF_CMD_STAT = 8'h04;
  localparam logic [7:0] OFF_CLASS_REV = 8'h08;
  localparam logic [7:0] OFF_HDR_MISC = 8'h0c;
  localparam logic [7:0] OFF_MEM_BASE = 8'h10;
  localparam logic [7:0] OFF_SUBSYSTEM = 8'h2c;
  localparam logic [7:0] OFF_INT_ROUTE = 8'h3c;
  // Unused, expansion ROM and reserved words, all reading zero
  localparam logic [7:0] OFF_UNUSED_BASE_1 = 8'h14;
  localparam logic [7:0] OFF_UNUSED_BASE_2 = 8'h18;
  localparam logic [7:0] OFF_UNUSED_BASE_3 = 8'h1c;
  localparam logic [7:0] OFF_UNUSED_BASE_4 = 8'h20;
  localparam logic [7:0] OFF_UNUSED_BASE_5 = 8'h24;
  localparam logic [7:0] OFF_RSVD_A = 8'h28;
  localparam logic [7:0] OFF_EXP_ROM = 8'h30;
  localparam logic [7:0] OFF_RSVD_B = 8'h34;
  localparam logic [7:0] OFF_RSVD_C = 8'h38;
  // Status bit positions
  localparam int ST_PARITY_BIT = 31;
  localparam int ST_SYSERR_BIT = 30;
  localparam int ST_TABORT_BIT = 27;
  localparam int ST_MPERR_BIT = 24;
  localparam int ST_FAST_B2B_BIT = 23;
  // Command bit positions
  localparam int CMD_SERR_EN_BIT = 8;
  localparam int CMD_PARITY_EN_BIT = 6;
  localparam int CMD_MEM_EN_BIT = 1;
  localparam int CMD_IO_EN_BIT = 0;
  // Fixed field values
  localparam logic [23:0] CLASS_CODE = 24'h070002;
  localparam logic [7:0] HEADER_TYPE = 8'h00;
  localparam logic [7:0] SELF_TEST = 8'h00;
  localparam logic [7:0] INT_PIN_VALUE = 8'h01;
  // Memory window: 4K, base held in bits 31:12
  localparam int WIN_LSB = 12;
  // Values after reset
  localparam logic [31:0] SUBSYSTEM_RESET = 32'h00000000;
  localparam logic [19:0] MEM_BASE_RESET = 20'h00000;
  localparam logic [7:0] INT_LINE_RESET = 8'h00;
  // EEPROM load targets
  localparam logic EE_SEL_IDENTITY = 1'h0;
  localparam logic EE_SEL_SUBSYSTEM = 1'h1;
endpackage : pcs_pkg

/* rtl/pcs_config_regs.sv */
// Configuration space header registers for a single-function memory target.
// Assumes a bus front end that decodes configuration cycles into one-cycle
// read and write strobes, and an EEPROM loader that presents whole words.
`timescale 1ns/10ps
`default_nettype none

module pcs_config_regs #(
  parameter logic [15:0] DEVICE_ID_DEFAULT = 16'h0a5a, // Arbitrary value
  parameter logic [15:0] VENDOR_ID_DEFAULT = 16'h05a5, // Arbitrary value
  parameter logic [7:0] REVISION = 8'h01
) (
  input wire logic clk,
  input wire logic arst_n,
  // Configuration access, one-cycle strobes
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_be_n,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // EEPROM load words
  input wire logic ee_load,
  input wire logic ee_sel,
  input wire logic [31:0] ee_data,
  // Bus events
  input wire logic parity_err_seen,
  input wire logic system_err_seen,
  input wire logic target_abort_done,
  // Error pin requests
  output logic perr_report,
  output logic serr_drive_en,
  // Memory and I/O claim decode
  input wire logic mem_req,
  input wire logic io_req,
  input wire logic [31:0] req_addr,
  output logic mem_claim,
  output logic io_claim,
  output logic [11:0] mem_offset,
  // Command bits for the rest of the device
  output logic serr_enable,
  output logic parity_enable,
  output logic mem_enable
);

  typedef struct packed {
    logic [31:0] identity;
    logic [31:0] subsystem;
    logic [19:0] mem_base;
    logic [7:0] int_line;
    logic [31:0] rdata;
    logic rvalid;
    logic perr;
    logic serr;
    logic claim;
    logic io;
    logic [11:0] offset;
  } pcs_state_s;

  pcs_state_s st;
  pcs_state_s next_st;
  logic [31:0] rd_word;
  logic [31:0] cmd_stat;
  logic [31:0] wmask;
  logic flag_parity;
  logic flag_syserr;
  logic flag_tabort;
  logic cmd_serr_en;
  logic cmd_parity_en;
  logic cmd_mem_en;
  logic [7:0] word_addr;
  logic sel_cmd_stat;
  logic sel_mem_base;
  logic sel_int_route;
  logic clear_parity;
  logic clear_syserr;
  logic wr_cmd_serr;
  logic wr_cmd_parity;
  logic wr_cmd_mem;

  // Assemble the command and status word
  always_comb begin
    cmd_stat = 32'h00000000;
    cmd_stat[pcs_pkg::ST_PARITY_BIT] = flag_parity;
    cmd_stat[pcs_pkg::ST_SYSERR_BIT] = flag_syserr;
    cmd_stat[pcs_pkg::ST_TABORT_BIT] = flag_tabort;
    cmd_stat[pcs_pkg::ST_MPERR_BIT] = 1'b0;
    cmd_stat[pcs_pkg::ST_FAST_B2B_BIT] = 1'b1;
    cmd_stat[pcs_pkg::CMD_SERR_EN_BIT] = cmd_serr_en;
    cmd_stat[pcs_pkg::CMD_PARITY_EN_BIT] = cmd_parity_en;
    cmd_stat[pcs_pkg::CMD_MEM_EN_BIT] = cmd_mem_en;
    cmd_stat[pcs_pkg::CMD_IO_EN_BIT] = 1'b0;
  end

  // Read multiplexer over the header words
  always_comb begin
    rd_word = 32'h00000000;
    unique case (word_addr)
      pcs_pkg::OFF_IDENTITY: rd_word = st.identity;
      pcs_pkg::OFF_CMD_STAT: rd_word = cmd_stat;
      pcs_pkg::OFF_CLASS_REV: rd_word = {pcs_pkg::CLASS_CODE, REVISION};
      // header and self-test, zero timer bytes
      pcs_pkg::OFF_HDR_MISC: rd_word = {pcs_pkg::SELF_TEST, pcs_pkg::HEADER_TYPE, 16'h0000};
      pcs_pkg::OFF_MEM_BASE: rd_word = {st.mem_base, 12'h000};
      pcs_pkg::OFF_SUBSYSTEM: rd_word = st.subsystem;
      // interrupt pin one, latency bytes zero
      pcs_pkg::OFF_INT_ROUTE: rd_word = {16'h0000, pcs_pkg::INT_PIN_VALUE, st.int_line};
      // unused base address words read zero
      pcs_pkg::OFF_UNUSED_BASE_1: rd_word = 32'h00000000;
      pcs_pkg::OFF_UNUSED_BASE_2: rd_word = 32'h00000000;
      pcs_pkg::OFF_UNUSED_BASE_3: rd_word = 32'h00000000;
      pcs_pkg::OFF_UNUSED_BASE_4: rd_word = 32'h00000000;
      pcs_pkg::OFF_UNUSED_BASE_5: rd_word = 32'h00000000;
      pcs_pkg::OFF_EXP_ROM: rd_word = 32'h00000000;
      pcs_pkg::OFF_RSVD_A: rd_word = 32'h00000000;
      pcs_pkg::OFF_RSVD_B: rd_word = 32'h00000000;
      pcs_pkg::OFF_RSVD_C: rd_word = 32'h00000000;
      // Words outside the header read zero
      default: rd_word = 32'h00000000;
    endcase
  end

  // Byte enables to a bit mask, active high
  always_comb begin
    wmask = {{8{~cfg_be_n[3]}}, {8{~cfg_be_n[2]}}, {8{~cfg_be_n[1]}}, {8{~cfg_be_n[0]}}};
  end

  // Word decode of the configuration address, low bits ignored
  always_comb begin
    word_addr = {cfg_addr[7:2], 2'b00};
    sel_cmd_stat = (word_addr == pcs_pkg::OFF_CMD_STAT);
    sel_mem_base = (word_addr == pcs_pkg::OFF_MEM_BASE);
    sel_int_route = (word_addr == pcs_pkg::OFF_INT_ROUTE);
  end

  always_comb begin
    clear_parity = cfg_wr && sel_cmd_stat && wmask[pcs_pkg::ST_PARITY_BIT]
      && cfg_wdata[pcs_pkg::ST_PARITY_BIT];
    clear_syserr = cfg_wr && sel_cmd_stat && wmask[pcs_pkg::ST_SYSERR_BIT]
      && cfg_wdata[pcs_pkg::ST_SYSERR_BIT];
    wr_cmd_serr = cfg_wr && sel_cmd_stat && wmask[pcs_pkg::CMD_SERR_EN_BIT];
    wr_cmd_parity = cfg_wr && sel_cmd_stat && wmask[pcs_pkg::CMD_PARITY_EN_BIT];
    wr_cmd_mem = cfg_wr && sel_cmd_stat && wmask[pcs_pkg::CMD_MEM_EN_BIT];
  end

  // Next-state logic
  always_comb begin
    next_st = st;
    next_st.rvalid = cfg_rd;
    if (cfg_rd) begin
      next_st.rdata = rd_word;
    end
    // base address, upper 20 bits only
    if (cfg_wr && sel_mem_base) begin
      next_st.mem_base = (st.mem_base & ~wmask[31:12]) | (cfg_wdata[31:12] & wmask[31:12]);
    end
    // interrupt line byte; read-only words ignore writes
    if (cfg_wr && sel_int_route && !cfg_be_n[0]) begin
      next_st.int_line = cfg_wdata[7:0];
    end
    if (ee_load && (ee_sel == pcs_pkg::EE_SEL_IDENTITY)) begin
      next_st.identity = ee_data;
    end
    if (ee_load && (ee_sel == pcs_pkg::EE_SEL_SUBSYSTEM)) begin
      next_st.subsystem = ee_data;
    end
    next_st.perr = parity_err_seen && cmd_parity_en;
    next_st.serr = system_err_seen && cmd_serr_en;
    next_st.claim = mem_req && cmd_mem_en && (req_addr[31:12] == st.mem_base);
    next_st.offset = mem_req ? req_addr[11:0] : st.offset;
    next_st.io = io_req && 1'b0;
  end

  // State register; reset restores every field
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st.identity <= {DEVICE_ID_DEFAULT, VENDOR_ID_DEFAULT};
      st.subsystem <= pcs_pkg::SUBSYSTEM_RESET;
      st.mem_base <= pcs_pkg::MEM_BASE_RESET;
      st.int_line <= pcs_pkg::INT_LINE_RESET;
      st.rdata <= 32'h00000000;
      st.rvalid <= 1'b0;
      st.perr <= 1'b0;
      st.serr <= 1'b0;
      st.claim <= 1'b0;
      st.io <= 1'b0;
      st.offset <= 12'h000;
    end else begin
      st <= next_st;
    end
  end

  pcs_sticky_flag u_flag_parity (
    .clk(clk),
    .arst_n(arst_n),
    .set_evt(parity_err_seen),
    .clear_req(clear_parity),
    .flag(flag_parity)
  );

  pcs_sticky_flag u_flag_syserr (
    .clk(clk),
    .arst_n(arst_n),
    .set_evt(system_err_seen),
    .clear_req(clear_syserr),
    .flag(flag_syserr)
  );

  pcs_sticky_flag u_flag_tabort (
    .clk(clk),
    .arst_n(arst_n),
    .set_evt(target_abort_done),
    .clear_req(1'b0),
    .flag(flag_tabort)
  );

  pcs_rw_field #(
    .WIDTH(1)
  ) u_cmd_serr_en (
    .clk(clk),
    .arst_n(arst_n),
    .wr_en(wr_cmd_serr),
    .wr_data(cfg_wdata[pcs_pkg::CMD_SERR_EN_BIT]),
    .value(cmd_serr_en)
  );

  pcs_rw_field #(
    .WIDTH(1)
  ) u_cmd_parity_en (
    .clk(clk),
    .arst_n(arst_n),
    .wr_en(wr_cmd_parity),
    .wr_data(cfg_wdata[pcs_pkg::CMD_PARITY_EN_BIT]),
    .value(cmd_parity_en)
  );

  pcs_rw_field #(
    .WIDTH(1)
  ) u_cmd_mem_en (
    .clk(clk),
    .arst_n(arst_n),
    .wr_en(wr_cmd_mem),
    .wr_data(cfg_wdata[pcs_pkg::CMD_MEM_EN_BIT]),
    .value(cmd_mem_en)
  );

  // Outputs straight from the state register and the command field registers
  assign cfg_rdata = st.rdata;
  assign cfg_rvalid = st.rvalid;
  assign perr_report = st.perr;
  assign serr_drive_en = st.serr;
  assign mem_claim = st.claim;
  assign io_claim = st.io;
  assign mem_offset = st.offset;
  assign serr_enable = cmd_serr_en;
  assign parity_enable = cmd_parity_en;
  assign mem_enable = cmd_mem_en;

endmodule // pcs_config_regs

// Sticky status flag: an event sets it, a clear request or reset clears it
module pcs_sticky_flag (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic set_evt,
  input wire logic clear_req,
  output logic flag
);

  typedef struct packed {
    logic flag;
  } pcs_flag_s;

  pcs_flag_s st;
  pcs_flag_s next_st;

  // Set is applied last so an event wins over a same-cycle clear
  always_comb begin
    next_st = st;
    if (clear_req) begin
      next_st.flag = 1'b0;
    end
    if (set_evt) begin
      next_st.flag = 1'b1;
    end
  end

  // Flag register, low after reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st.flag <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // Flag output straight from its register
  assign flag = st.flag;

endmodule // pcs_sticky_flag

// Host-writable field: a write with its lane enabled loads it, reset clears it
module pcs_rw_field #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] value
);

  typedef struct packed {
    logic [WIDTH-1:0] value;
  } pcs_field_s;

  pcs_field_s st;
  pcs_field_s next_st;

  // Load on an enabled write, otherwise hold
  always_comb begin
    next_st = st;
    if (wr_en) begin
      next_st.value = wr_data;
    end
  end

  // Field register, zero after reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st.value <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Field output straight from its register
  assign value = st.value;

endmodule // pcs_rw_field

`default_nettype wire

/* verification/pcs_config_regs_props.sv */
// Concurrent checks on the configuration header ports.
// Assumes binding onto pcs_config_regs, one clock domain.
`timescale 1ns/10ps
`default_nettype none
module pcs_cfg_props (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cfg_rd,
  input wire logic cfg_rvalid,
  input wire logic mem_req,
  input wire logic mem_enable,
  input wire logic mem_claim,
  input wire logic io_claim,
  input wire logic parity_err_seen,
  input wire logic parity_enable,
  input wire logic perr_report,
  input wire logic system_err_seen,
  input wire logic serr_enable,
  input wire logic serr_drive_en,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Word index of the request
  logic [5:0] w;
  assign w = cfg_addr[7:2];
  AST_RVALID: assert property (cfg_rd |=> cfg_rvalid) else $error("read not answered");
  AST_STATUS: assert property (cfg_rd && w == 6'h01 |=> cfg_rdata[24:23] == 2'b01
    && !cfg_rdata[0]) else $error("status fixed bits wrong");
  AST_CLASS: assert property (cfg_rd && w == 6'h02
    |=> cfg_rdata[31:8] == pcs_pkg::CLASS_CODE) else $error("class code wrong");
  AST_BASE_LOW: assert property (cfg_rd && w == 6'h04 |=> cfg_rdata[11:0] == 12'h000)
    else $error("base low bits not zero");
  AST_ZERO_WORDS: assert property (cfg_rd && w inside {6'h03, [6'h05:6'h0a], [6'h0c:6'h0e]}
    |=> cfg_rdata == 32'h00000000) else $error("zero word not zero");
  AST_INT_PIN: assert property (cfg_rd && w == 6'h0f |=> cfg_rdata[31:8] == 24'h000001)
    else $error("interrupt pin word wrong");
  AST_IO_NEVER: assert property (!io_claim) else $error("io claimed");
  AST_MEM_GATE: assert property (mem_req && !mem_enable |=> !mem_claim)
    else $error("claim while disabled");
  AST_PERR: assert property (perr_report == ($past(parity_err_seen) && $past(parity_enable)))
    else $error("parity report wrong");
  AST_SERR: assert property (serr_drive_en == ($past(system_err_seen) && $past(serr_enable)))
    else $error("system error drive wrong");
endmodule // pcs_cfg_props
bind pcs_config_regs pcs_cfg_props u_props (
  .clk(clk),
  .arst_n(arst_n),
  .cfg_rd(cfg_rd),
  .cfg_rvalid(cfg_rvalid),
  .mem_req(mem_req),
  .mem_enable(mem_enable),
  .mem_claim(mem_claim),
  .io_claim(io_claim),
  .parity_err_seen(parity_err_seen),
  .parity_enable(parity_enable),
  .perr_report(perr_report),
  .system_err_seen(system_err_seen),
  .serr_enable(serr_enable),
  .serr_drive_en(serr_drive_en),
  .cfg_addr(cfg_addr),
  .cfg_rdata(cfg_rdata)
);
`default_nettype wire

/* verification/pcs_host_model.sv */
// Host bridge model issuing configuration reads and writes.
// Assumes one-cycle strobes and a read answer one edge later.
`timescale 1ns/10ps
`default_nettype none
module pcs_host_model (
  input wire logic clk,
  output logic cfg_rd, cfg_wr,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_be_n,
  output logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic cfg_rvalid
);
  initial {cfg_rd, cfg_wr, cfg_addr, cfg_be_n, cfg_wdata} = {2'b00, 8'h00, 4'hf, 32'h00000000};
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] v);
    @(posedge clk);
    #1 {cfg_wr, cfg_addr, cfg_be_n, cfg_wdata} = {1'b1, a, be, v};
    @(posedge clk);
    #1 {cfg_wr, cfg_addr, cfg_be_n, cfg_wdata} = {1'b0, ~a, 4'hf, ~v};
  endtask
  // Read, answer taken one edge later
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    #1 {cfg_rd, cfg_addr} = {1'b1, a};
    @(posedge clk);
    #1 {cfg_rd, cfg_addr} = {1'b0, ~a};
    v = cfg_rvalid ? cfg_rdata : 32'hxxxxxxxx;
  endtask
endmodule // pcs_host_model
`default_nettype wire

/* verification/pcs_config_regs_tb.sv */
// Self-checking bench for the configuration header registers.
// Assumes the host model drives the configuration strobes.
`timescale 1ns/10ps
`default_nettype none
module pcs_config_regs_tb;
  logic clk = 1'b0, arst_n = 1'b0;
  logic cfg_rd, cfg_wr, cfg_rvalid, perr_report, serr_drive_en, mem_claim, io_claim;
  logic serr_enable, parity_enable, mem_enable, ee_sel = 1'b0;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_be_n;
  logic [31:0] cfg_wdata, cfg_rdata, d, ee_data = 32'h00000000, req_addr = 32'h00000000;
  logic [11:0] mem_offset;
  logic [5:0] ev = 6'h00;
  logic [31:0] e [16];
  int n_errors = 0, num_checks = 0;
  always #10 clk = ~clk;
  pcs_host_model u_host (.*);
  pcs_config_regs u_dut (.*, .ee_load(ev[5]), .parity_err_seen(ev[4]), .system_err_seen(ev[3]),
    .target_abort_done(ev[2]), .mem_req(ev[1]), .io_req(ev[0]));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One-cycle event pulse, outputs settled on return
  task automatic pulse(input logic [5:0] v);
    @(posedge clk);
    #1 ev = v;
    @(posedge clk);
    #1 ev = 6'h00;
  endtask
  task automatic rd_all();
    for (int i = 0; i < 16; i++) begin
      u_host.rd(8'(i * 4), d);
      chk("config word", d, e[i]);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
  initial begin
    foreach (e[i]) e[i] = 32'h00000000;
    e[0] = 32'h0a5a05a5;
    e[1] = 32'h00800000;
    e[2] = 32'h07000201;
    e[15] = 32'h00000100;
    repeat (3) @(posedge clk);
    #1 arst_n = 1'b1;
    rd_all();
    // Ones everywhere, only writable bits keep them
    for (int i = 0; i < 16; i++) u_host.wr(8'(i * 4), 4'h0, 32'hffffffff);
    e[1] = 32'h00800142;
    e[4] = 32'hfffff000;
    e[15] = 32'h000001ff;
    rd_all();
    chk("command enables on", {serr_enable, parity_enable, mem_enable}, 3'b111);
    pulse(6'h1c);
    chk("perr_report", perr_report, 1'b1);
    chk("serr_drive_en", serr_drive_en, 1'b1);
    u_host.rd(8'h04, d);
    chk("status set", d, 32'hc8800142);
    u_host.wr(8'h04, 4'h7, 32'h40000000);
    u_host.rd(8'h04, d);
    chk("status clear 30", d, 32'h88800142);
    u_host.wr(8'h04, 4'h7, 32'h88000000);
    u_host.rd(8'h04, d);
    chk("status clear 31", d, 32'h08800142);
    req_addr = 32'hfffff080;
    pulse(6'h02);
    chk("claim", {mem_claim, 8'h00, mem_offset}, 21'h100080);
    req_addr = 32'h00001080;
    pulse(6'h03);
    chk("outside claim", {mem_claim, io_claim}, 2'b00);
    u_host.wr(8'h04, 4'h0, 32'h00000000);
    chk("command enables off", {serr_enable, parity_enable, mem_enable}, 3'b000);
    req_addr = 32'hfffff080;
    pulse(6'h12);
    chk("disabled", {mem_claim, perr_report}, 2'b00);
    ee_data = 32'h11112222;
    pulse(6'h20);
    ee_sel = 1'b1;
    ee_data = 32'h33334444;
    pulse(6'h20);
    u_host.rd(8'h00, d);
    chk("identity", d, 32'h11112222);
    u_host.rd(8'h2c, d);
    chk("subsystem", d, 32'h33334444);
    // Reset in mid-run returns every field
    @(posedge clk);
    #1 arst_n = 1'b0;
    @(posedge clk);
    #1 arst_n = 1'b1;
    e[1] = 32'h00800000;
    e[4] = 32'h00000000;
    e[15] = 32'h00000100;
    rd_all();
    report_and_stop();
  end
endmodule // pcs_config_regs_tb
`default_nettype wire
